// [rtl/smf_front_end.sv]
`timescale 1ns/100ps
// Function
// - Each character: start, eight data bits, one stop bit, both directions.
// - No parity bit and no flow control on the serial link.
// - Carriage return ends the current message.
// - Line feed bytes are thrown away, never stored nor ending a message.
// - Rate picks 1200 to 19200 bps; 9600 after reset.
// - Rate setting only affects the two serial ports.
// - Unit address held in range 1 through 30.
// - Act only when addressed or selected, or on a select command; otherwise ignore the command.
// - A selected unit executes every command carrying no address.
// - An explicit address overrides the selection.
// - Select command: matching unit selects, all others deselect.
// - One of five remote ports is the active command source.
// - Front panel lockout keeps the chosen port active.
// - Single-address command is answered by that unit, selected or not.
// - Broadcast or multi-address: only selected unit replies, else nobody.
module smf_front_end #(
  parameter int P_CLK_HZ = 100_000_000
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_se_rx,
  input wire logic i_md_rx,
  input wire logic [2:0] i_rate_sel,
  input wire smf_pkg::smf_port_e i_port_sel,
  input wire logic i_lockout,
  input wire logic [4:0] i_unit_addr,
  input wire logic i_adapter_valid,
  input wire logic [7:0] i_adapter_data,
  output logic o_adapter_ready,
  output smf_pkg::smf_byte_s o_msg,
  output logic o_msg_valid,
  input wire logic i_msg_ready,
  output logic o_rx_overrun,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_se_tx,
  output logic o_md_tx,
  output logic o_md_tx_oe,
  input wire logic i_route_valid,
  input wire smf_pkg::smf_route_s i_route,
  output logic o_execute,
  output logic o_reply_en,
  output logic o_selected
);

  function automatic logic [16:0] bit_cycles(input logic [2:0] code);
    bit_cycles = 17'(P_CLK_HZ / smf_pkg::rate_bps(code));
  endfunction : bit_cycles

  // ----------------------------------------
  // Pin synchronisers and configuration
  // ----------------------------------------
  logic [2:0] se_sync_q, se_sync_d, md_sync_q, md_sync_d;
  logic se_lvl_q, se_lvl_d, md_lvl_q, md_lvl_d;
  logic [2:0] rate_q, rate_d;
  logic [4:0] addr_q, addr_d;
  smf_pkg::smf_port_e port_q, port_d;
  logic serial_port;

  always_comb begin
    se_sync_d = {se_sync_q[1:0], i_se_rx};
    md_sync_d = {md_sync_q[1:0], i_md_rx};
    se_lvl_d = (se_sync_q[1] == se_sync_q[2]) ? se_sync_q[2] : se_lvl_q;
    md_lvl_d = (md_sync_q[1] == md_sync_q[2]) ? md_sync_q[2] : md_lvl_q;
    port_d = i_lockout ? port_q : i_port_sel;
    rate_d = (!i_lockout && i_rate_sel <= smf_pkg::RATE_19200) ? i_rate_sel : rate_q;
    addr_d = (i_unit_addr >= smf_pkg::ADDR_MIN && i_unit_addr <= smf_pkg::ADDR_MAX)
             ? i_unit_addr : addr_q;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      se_sync_q <= 3'h7;
      md_sync_q <= 3'h7;
      se_lvl_q <= 1'b1;
      md_lvl_q <= 1'b1;
      port_q <= smf_pkg::PORT_RESET;
      rate_q <= smf_pkg::RATE_RESET;
      addr_q <= smf_pkg::ADDR_RESET;
    end else if (i_clk_en) begin
      se_sync_q <= se_sync_d;
      md_sync_q <= md_sync_d;
      se_lvl_q <= se_lvl_d;
      md_lvl_q <= md_lvl_d;
      port_q <= port_d;
      rate_q <= rate_d;
      addr_q <= addr_d;
    end
  end

  // Adapters carry whole bytes, so bit timing touches only the serial ports
  assign serial_port = (port_q == smf_pkg::SMF_PORT_SE)
                     || (port_q == smf_pkg::SMF_PORT_MD);

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } smf_rx_e;
  smf_rx_e rx_st_q, rx_st_d;
  logic [16:0] rx_cnt_q, rx_cnt_d;
  logic [2:0] rx_nbit_q, rx_nbit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_done, rx_line;

  assign rx_line = (port_q == smf_pkg::SMF_PORT_MD) ? md_lvl_q
                 : (port_q == smf_pkg::SMF_PORT_SE) ? se_lvl_q : 1'b1;

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = (rx_cnt_q == 17'h0) ? bit_cycles(rate_q) - 17'h1 : rx_cnt_q - 17'h1;
    rx_nbit_d = rx_nbit_q;
    rx_sh_d = rx_sh_q;
    rx_done = 1'b0;
    unique case (rx_st_q)
      RX_IDLE: begin
        if (!rx_line) begin
          rx_st_d = RX_START;
          rx_cnt_d = bit_cycles(rate_q) >> 1;
        end
      end
      RX_START: begin
        if (rx_cnt_q == 17'h0) begin
          rx_st_d = rx_line ? RX_IDLE : RX_DATA;
          rx_nbit_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_cnt_q == 17'h0) begin
          rx_sh_d = {rx_line, rx_sh_q[7:1]};
          rx_nbit_d = rx_nbit_q + 3'h1;
          if (rx_nbit_q == 3'(smf_pkg::DATA_BITS - 1)) begin
            rx_st_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cnt_q == 17'h0) begin
          rx_done = rx_line;
          rx_st_d = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 17'h0;
      rx_nbit_q <= 3'h0;
      rx_sh_q <= 8'h0;
    end else if (i_clk_en) begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_nbit_q <= rx_nbit_d;
      rx_sh_q <= rx_sh_d;
    end
  end

  // ----------------------------------------
  // Two-entry message buffer
  // ----------------------------------------
  smf_pkg::smf_byte_s head_q, head_d, skid_q, skid_d, in_byte;
  logic head_v_q, head_v_d, skid_v_q, skid_v_d, ovr_q, ovr_d, ready_q;
  logic in_valid, push, pop, from_adapter;

  always_comb begin
    from_adapter = !serial_port && i_adapter_valid && ready_q;
    in_byte.data = from_adapter ? i_adapter_data : rx_sh_q;
    in_byte.eom = (in_byte.data == smf_pkg::CHAR_CR);
    in_valid = from_adapter || (serial_port && rx_done);
    push = in_valid && (in_byte.data != smf_pkg::CHAR_LF);
    pop = head_v_q && i_msg_ready;
    head_d = head_q;
    head_v_d = head_v_q;
    skid_d = skid_q;
    skid_v_d = skid_v_q;
    ovr_d = 1'b0;
    if (pop) begin
      head_d = skid_v_q ? skid_q : in_byte;
      head_v_d = skid_v_q || push;
      skid_d = in_byte;
      skid_v_d = skid_v_q && push;
    end else if (push) begin
      if (!head_v_q) begin
        head_d = in_byte;
        head_v_d = 1'b1;
      end else if (!skid_v_q) begin
        skid_d = in_byte;
        skid_v_d = 1'b1;
      end else begin
        ovr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      head_q <= '0;
      skid_q <= '0;
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      ovr_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (i_clk_en) begin
      head_q <= head_d;
      skid_q <= skid_d;
      head_v_q <= head_v_d;
      skid_v_q <= skid_v_d;
      ovr_q <= ovr_d;
      ready_q <= !skid_v_d;
    end
  end

  assign o_msg = head_q;
  assign o_msg_valid = head_v_q;
  assign o_rx_overrun = ovr_q;
  assign o_adapter_ready = ready_q;

  // ----------------------------------------
  // Serial transmitter
  // ----------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } smf_tx_e;
  smf_tx_e tx_st_q, tx_st_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d;
  logic [16:0] tx_cnt_q, tx_cnt_d;
  logic se_tx_q, se_tx_d, md_tx_q, md_tx_d, md_oe_q, md_oe_d, tx_rdy_q;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_cnt_d = tx_cnt_q - 17'h1;
    unique case (tx_st_q)
      TX_IDLE: begin
        // Replies that may not be sent are taken and dropped to avoid bus clashes
        if (i_tx_valid && tx_rdy_q && serial_port && o_reply_en) begin
          tx_sh_d = {1'b1, i_tx_data, 1'b0};
          tx_left_d = 4'(smf_pkg::FRAME_BITS);
          tx_cnt_d = bit_cycles(rate_q) - 17'h1;
          tx_st_d = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_cnt_q == 17'h0) begin
          tx_sh_d = {1'b1, tx_sh_q[9:1]};
          tx_left_d = tx_left_q - 4'h1;
          tx_cnt_d = bit_cycles(rate_q) - 17'h1;
          if (tx_left_q == 4'h1) begin
            tx_st_d = TX_IDLE;
          end
        end
      end
    endcase
    se_tx_d = (tx_st_d == TX_SEND && port_q == smf_pkg::SMF_PORT_SE) ? tx_sh_d[0] : 1'b1;
    md_oe_d = (tx_st_d == TX_SEND && port_q == smf_pkg::SMF_PORT_MD);
    md_tx_d = md_oe_d ? tx_sh_d[0] : 1'b1;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 10'h3ff;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 17'h0;
      se_tx_q <= 1'b1;
      md_tx_q <= 1'b1;
      md_oe_q <= 1'b0;
      tx_rdy_q <= 1'b0;
    end else if (i_clk_en) begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_cnt_q <= tx_cnt_d;
      se_tx_q <= se_tx_d;
      md_tx_q <= md_tx_d;
      md_oe_q <= md_oe_d;
      tx_rdy_q <= (tx_st_d == TX_IDLE) && !(i_tx_valid && tx_rdy_q);
    end
  end

  assign o_se_tx = se_tx_q;
  assign o_md_tx = md_tx_q;
  assign o_md_tx_oe = md_oe_q;
  assign o_tx_ready = tx_rdy_q;

  // ----------------------------------------
  // Multichannel routing
  // ----------------------------------------
  logic sel_q, sel_d, exec_q, exec_d, reply_q, reply_d;
  logic mine, single;

  always_comb begin
    mine = i_route.addr_mask[addr_q];
    single = !i_route.addr_mask[0] && $onehot(i_route.addr_mask[30:1]);
    sel_d = sel_q;
    exec_d = 1'b0;
    reply_d = reply_q;
    if (i_route_valid) begin
      if (i_route.sel_cmd) begin
        sel_d = (i_route.sel_addr == addr_q);
      end
      // Address present decides alone; selection only covers bare commands
      exec_d = i_route.sel_cmd || (i_route.has_addr ? (mine || i_route.addr_mask[0])
               : sel_q);
      reply_d = (i_route.has_addr && single) ? mine : sel_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      exec_q <= 1'b0;
      reply_q <= 1'b0;
    end else if (i_clk_en) begin
      sel_q <= sel_d;
      exec_q <= exec_d;
      reply_q <= reply_d;
    end
  end

  assign o_selected = sel_q;
  assign o_execute = exec_q;
  assign o_reply_en = reply_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Watched at the output, so a broken filter upstream still shows
  chk_lf_discard: assert property (
    o_msg_valid |-> o_msg.data != smf_pkg::CHAR_LF)
    else $error("LF stored");
  chk_cr_eom: assert property (
    o_msg_valid |-> o_msg.eom == (o_msg.data == smf_pkg::CHAR_CR))
    else $error("CR not end");
  chk_tx_frame: assert property (
    i_clk_en && tx_st_q == TX_IDLE && tx_st_d == TX_SEND
    |=> tx_sh_q[0] == 1'b0 && tx_sh_q[9] == 1'b1 && tx_left_q == 4'ha)
    else $error("Bad frame");
  chk_addr_range: assert property (
    addr_q >= smf_pkg::ADDR_MIN && addr_q <= smf_pkg::ADDR_MAX)
    else $error("Address out of range");
  chk_lock_hold: assert property (
    i_lockout ##1 i_lockout |-> $stable(port_q))
    else $error("Port moved under lock");
  chk_select_drop: assert property (
    i_clk_en && i_route_valid && i_route.sel_cmd && i_route.sel_addr != addr_q
    |=> !o_selected)
    else $error("Stale selection");
  chk_ignore_other: assert property (
    i_clk_en && i_route_valid && !i_route.sel_cmd && i_route.has_addr && !mine
    && !i_route.addr_mask[0] |=> !o_execute)
    else $error("Foreign command run");
  chk_bare_selected: assert property (
    i_clk_en && i_route_valid && !i_route.has_addr && sel_q |=> o_execute)
    else $error("Selected unit skipped");
  chk_single_reply: assert property (
    i_clk_en && i_route_valid && i_route.has_addr && single && mine |=> o_reply_en)
    else $error("Addressed unit silent");
  chk_multi_quiet: assert property (
    i_clk_en && i_route_valid && !i_route.sel_cmd && i_route.has_addr && !single
    && !sel_q |=> !o_reply_en ##1 (!o_reply_en || $past(i_route_valid)))
    else $error("Unselected reply");

  cov_rx_byte: cover property (push && serial_port);
  cov_select: cover property (i_route_valid && i_route.sel_cmd ##1 o_selected);
  cov_buffer_full: cover property (skid_v_q && head_v_q);
  cov_md_send: cover property (o_md_tx_oe);

endmodule : smf_front_end

// [rtl/smf_pkg.sv]
package smf_pkg;

  // ----------------------------------------
  // Character framing
  // ----------------------------------------
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;

  // ----------------------------------------
  // Bit rates
  // ----------------------------------------
  localparam logic [2:0] RATE_1200 = 3'h0;
  localparam logic [2:0] RATE_2400 = 3'h1;
  localparam logic [2:0] RATE_4800 = 3'h2;
  localparam logic [2:0] RATE_9600 = 3'h3;
  localparam logic [2:0] RATE_19200 = 3'h4;
  localparam logic [2:0] RATE_RESET = RATE_9600;
  localparam int BPS_1200 = 1200;
  localparam int BPS_2400 = 2400;
  localparam int BPS_4800 = 4800;
  localparam int BPS_9600 = 9600;
  localparam int BPS_19200 = 19200;

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] ADDR_RESET = ADDR_MIN;

  // ----------------------------------------
  // Remote ports
  // ----------------------------------------
  typedef enum logic [4:0] {
    SMF_PORT_SE = 5'b00001,
    SMF_PORT_MD = 5'b00010,
    SMF_PORT_USB = 5'b00100,
    SMF_PORT_PAR = 5'b01000,
    SMF_PORT_NET = 5'b10000
  } smf_port_e;
  localparam smf_port_e PORT_RESET = SMF_PORT_SE;

  typedef struct packed {
    logic eom;
    logic [7:0] data;
  } smf_byte_s;

  // Bit 0 of the mask is the broadcast (ALL) address
  typedef struct packed {
    logic has_addr;
    logic [30:0] addr_mask;
    logic sel_cmd;
    logic [4:0] sel_addr;
  } smf_route_s;

  function automatic int rate_bps(input logic [2:0] code);
    case (code)
      RATE_1200: rate_bps = BPS_1200;
      RATE_2400: rate_bps = BPS_2400;
      RATE_4800: rate_bps = BPS_4800;
      RATE_19200: rate_bps = BPS_19200;
      default: rate_bps = BPS_9600;
    endcase
  endfunction : rate_bps

endpackage : smf_pkg

// [sim/smf_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Host terminal on the serial pins
// ----------------------------------------
module smf_host_model (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_line
);
  int bit_cyc = 200;
  logic [7:0] got_q[$];
  logic [7:0] b;
  // Mark level between frames, as the pull-up would leave it
  initial o_line = 1'b1;

  // Start low, data LSB first, one stop, no parity, no flow control
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clock);
      o_line = fr[i];
      repeat (bit_cyc - 1) @(negedge i_clock);
    end
  endtask : send_byte

  // Bad stop bit loses the byte, so the bench sees it missing
  initial begin
    forever begin
      @(negedge i_line);
      repeat (bit_cyc / 2) @(posedge i_clock);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge i_clock);
        b[i] = i_line;
      end
      repeat (bit_cyc) @(posedge i_clock);
      if (i_line === 1'b1) got_q.push_back(b);
    end
  end
endmodule : smf_host_model

// [sim/tb_serial_multichannel_command_front_end.sv]
`timescale 1ns/100ps
module tb_serial_multichannel_command_front_end;
  logic i_clock, i_rst, i_clk_en, i_se_rx, i_md_rx, i_lockout, i_adapter_valid;
  logic i_tx_valid, i_route_valid, o_adapter_ready, o_msg_valid, o_rx_overrun;
  logic o_tx_ready, o_se_tx, o_md_tx, o_md_tx_oe, o_execute, o_reply_en, o_selected;
  logic i_msg_ready = 1'b1;
  logic [2:0] i_rate_sel;
  logic [4:0] i_unit_addr;
  logic [7:0] i_adapter_data, i_tx_data, b;
  smf_pkg::smf_port_e i_port_sel;
  smf_pkg::smf_route_s i_route;
  smf_pkg::smf_byte_s o_msg, exp_b;
  smf_pkg::smf_byte_s exp_q[$];
  int bad_count = 0;
  int compares = 0;
  int stall = 0;
  int ovr_n = 0;
  int oe_n = 0;
  int me = 5;
  logic sel_m = 1'b0;
  logic [31:0] seed = 32'h0f9e4b44;
  int bps_tab[5] = '{1200, 2400, 4800, 9600, 19200};

  smf_front_end #(.P_CLK_HZ(1_920_000)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_se_rx(i_se_rx), .i_md_rx(i_md_rx), .i_rate_sel(i_rate_sel),
    .i_port_sel(i_port_sel), .i_lockout(i_lockout), .i_unit_addr(i_unit_addr),
    .i_adapter_valid(i_adapter_valid), .i_adapter_data(i_adapter_data),
    .o_adapter_ready(o_adapter_ready), .o_msg(o_msg), .o_msg_valid(o_msg_valid),
    .i_msg_ready(i_msg_ready), .o_rx_overrun(o_rx_overrun), .i_tx_valid(i_tx_valid),
    .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready), .o_se_tx(o_se_tx), .o_md_tx(o_md_tx),
    .o_md_tx_oe(o_md_tx_oe), .i_route_valid(i_route_valid), .i_route(i_route),
    .o_execute(o_execute), .o_reply_en(o_reply_en), .o_selected(o_selected));
  smf_host_model i_host (.i_clock(i_clock), .i_line(o_se_tx), .o_line(i_se_rx));
  // Released pair rests at mark through the bus bias
  smf_host_model i_bus (.i_clock(i_clock), .i_line(o_md_tx_oe ? o_md_tx : 1'b1),
    .o_line(i_md_rx));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic wrap_up();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic hang();
    bad_count++;
    wrap_up();
  endtask : hang

  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : note

  task automatic cmp_bit(input logic got, input logic exp);
    note({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit

  task automatic cmp_msg(input smf_pkg::smf_byte_s got, input smf_pkg::smf_byte_s exp);
    note({23'h0, got}, {23'h0, exp});
  endtask : cmp_msg

  task automatic cmp_tx(input logic [7:0] got, input logic [7:0] exp);
    note({24'h0, got}, {24'h0, exp});
  endtask : cmp_tx

  // Line feed dropped, carriage return closes the message
  task automatic push_rx(input logic [7:0] d);
    if (d != 8'h0a) exp_q.push_back({d == 8'h0d, d});
  endtask : push_rx

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 40000) begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 40000) hang();
  endtask : drain

  task automatic adapt(input logic [7:0] d);
    int n;
    i_adapter_valid = 1'b1;
    i_adapter_data = d;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_adapter_ready !== 1'b1 && n < 500);
    if (n >= 500) hang();
    push_rx(d);
    @(negedge i_clock);
  endtask : adapt

  // Route model: execute, reply permission and selection from the record
  task automatic route(input logic ha, input logic [30:0] m, input logic sc,
    input logic [4:0] sa);
    logic ex, rp;
    i_route_valid = 1'b1;
    i_route = '{ha, m, sc, sa};
    ex = sc | (ha ? (m[me] | m[0]) : sel_m);
    if (sc) sel_m = (sa == me);
    rp = (ha && $countones(m) == 1 && !m[0]) ? m[me] : sel_m;
    @(negedge i_clock);
    i_route_valid = 1'b0;
    cmp_bit(o_execute, ex);
    cmp_bit(o_reply_en, rp);
    cmp_bit(o_selected, sel_m);
    @(negedge i_clock);
  endtask : route

  task automatic send_tx(input logic [7:0] d);
    int n;
    i_tx_valid = 1'b1;
    i_tx_data = d;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_tx_ready !== 1'b1 && n < 100);
    if (n >= 100) hang();
    @(negedge i_clock);
    i_tx_valid = 1'b0;
    repeat (2500) @(negedge i_clock);
  endtask : send_tx

  // Random stall of the consumer, or a hard stall to fill the buffer
  always @(negedge i_clock) begin
    i_msg_ready <= (stall == 0) || (stall == 1 && rnd() > 32'h7fffffff);
  end

  always @(posedge i_clock) begin
    if (o_msg_valid === 1'b1 && i_msg_ready === 1'b1) begin
      exp_b = 'x;
      if (exp_q.size() != 0) exp_b = exp_q.pop_front();
      cmp_msg(o_msg, exp_b);
    end
    if (o_rx_overrun === 1'b1) ovr_n++;
    if (o_md_tx_oe === 1'b1) oe_n++;
  end

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rst = 1'b1;
    i_clk_en = 1'b1;
    i_rate_sel = 3'h3;
    i_port_sel = smf_pkg::SMF_PORT_SE;
    i_lockout = 1'b0;
    i_unit_addr = 5'h05;
    i_adapter_valid = 1'b0;
    i_adapter_data = 8'h00;
    i_tx_valid = 1'b0;
    i_tx_data = 8'h00;
    i_route_valid = 1'b0;
    i_route = '0;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clock);
    cmp_bit(o_se_tx, 1'b1);
    cmp_bit(o_md_tx_oe, 1'b0);
    for (int r = 0; r < 5; r++) begin
      i_rate_sel = r[2:0];
      i_host.bit_cyc = 1920000 / bps_tab[r];
      repeat (4) @(negedge i_clock);
      b = {1'b1, 7'(rnd())};
      push_rx(b);
      i_host.send_byte(b);
    end
    i_rate_sel = 3'h3;
    i_host.bit_cyc = 200;
    repeat (4) @(negedge i_clock);
    push_rx(8'h0a);
    i_host.send_byte(8'h0a);
    push_rx(8'h41);
    i_host.send_byte(8'h41);
    push_rx(8'h0d);
    i_host.send_byte(8'h0d);
    i_lockout = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rate_sel = 3'h0;
    i_port_sel = smf_pkg::SMF_PORT_USB;
    repeat (4) @(negedge i_clock);
    push_rx(8'h5a);
    i_host.send_byte(8'h5a);
    drain();
    i_lockout = 1'b0;
    stall = 2;
    repeat (4) @(negedge i_clock);
    adapt(8'h31);
    adapt(8'h32);
    i_adapter_valid = 1'b0;
    repeat (3) @(negedge i_clock);
    cmp_bit(o_adapter_ready, 1'b0);
    stall = 1;
    for (int k = 0; k < 16; k++) adapt(k == 15 ? 8'h0d : k % 5 == 2 ? 8'h0a : 8'(rnd()));
    i_adapter_valid = 1'b0;
    drain();
    stall = 0;
    route(1'b0, 31'h0, 1'b0, 5'h00);
    route(1'b1, 31'h20, 1'b0, 5'h00);
    route(1'b1, 31'h80, 1'b0, 5'h00);
    route(1'b1, 31'h1, 1'b0, 5'h00);
    route(1'b0, 31'h0, 1'b1, 5'h05);
    route(1'b0, 31'h0, 1'b0, 5'h00);
    route(1'b1, 31'h80, 1'b0, 5'h00);
    route(1'b1, 31'ha0, 1'b0, 5'h00);
    route(1'b0, 31'h0, 1'b1, 5'h07);
    route(1'b1, 31'h1, 1'b0, 5'h00);
    i_unit_addr = 5'h1f;
    repeat (3) @(negedge i_clock);
    route(1'b0, 31'h0, 1'b1, 5'h05);
    i_unit_addr = 5'h1e;
    me = 30;
    i_port_sel = smf_pkg::SMF_PORT_SE;
    i_rate_sel = 3'h3;
    repeat (3) @(negedge i_clock);
    route(1'b1, 31'h40000000, 1'b0, 5'h00);
    b = 8'(rnd());
    send_tx(b);
    cmp_bit(i_host.got_q.size() == 1, 1'b1);
    if (i_host.got_q.size() != 0) cmp_tx(i_host.got_q.pop_front(), b);
    route(1'b1, 31'h2, 1'b0, 5'h00);
    send_tx(8'h55);
    cmp_bit(i_host.got_q.size() == 0, 1'b1);
    route(1'b1, 31'h40000000, 1'b0, 5'h00);
    // Slaves on the pair only keep up at 9600
    i_port_sel = smf_pkg::SMF_PORT_MD;
    i_rate_sel = 3'h3;
    repeat (3) @(negedge i_clock);
    b = 8'(rnd());
    send_tx(b);
    note(oe_n, smf_pkg::FRAME_BITS * (1920000 / 9600));
    cmp_bit(i_bus.got_q.size() == 1, 1'b1);
    if (i_bus.got_q.size() != 0) cmp_tx(i_bus.got_q.pop_front(), b);
    // Consumer held off: two bytes fit, the third is lost
    stall = 2;
    repeat (4) @(negedge i_clock);
    for (int k = 0; k < 3; k++) begin
      b = {2'b01, 6'(rnd())};
      if (k < 2) push_rx(b);
      i_bus.send_byte(b);
    end
    note(ovr_n, 32'h1);
    stall = 0;
    drain();
    wrap_up();
  end
endmodule : tb_serial_multichannel_command_front_end
